// file: rtl/dpf_host_if.sv
// Host pin interface of the dual-port flash, with its receive FIFO
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Receive FIFO: synchronous, valid/ready on both sides
// ------------------------------------------------------------------
module dpf_fifo #(
   parameter int W = dpf_pkg::FIFO_W,
   parameter int D = dpf_pkg::FIFO_D
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         clkEn,
   input  wire logic         inValid,
   input  wire logic [W-1:0] inData,
   output logic              inReady,
   output logic              outValid,
   output logic [W-1:0]      outData,
   input  wire logic         outReady
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wrPtr;
      logic [AW-1:0]       rdPtr;
      logic [AW:0]         count;
   } dpf_fifo_s;

   dpf_fifo_s r;
   dpf_fifo_s next_r;
   logic      doWr;
   logic      doRd;

   // Honest flags straight from the occupancy count
   assign inReady  = (r.count != D[AW:0]);
   assign outValid = (r.count != '0);
   assign outData  = r.mem[r.rdPtr];
   assign doWr     = inValid && inReady;
   assign doRd     = outValid && outReady;

   // Pointer and count update
   always_comb begin
      next_r = r;
      if (doWr) begin
         next_r.mem[r.wrPtr] = inData;
         next_r.wrPtr        = r.wrPtr + 1'b1;
      end
      if (doRd) begin
         next_r.rdPtr = r.rdPtr + 1'b1;
      end
      if (doWr && !doRd) begin
         next_r.count = r.count + 1'b1;
      end else if (doRd && !doWr) begin
         next_r.count = r.count - 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         r <= '0;
      end else if (clkEn) begin
         r <= next_r;
      end
   end
endmodule

// ------------------------------------------------------------------
// Pin interface top
// ------------------------------------------------------------------
module dpf_host_if (
   input  wire logic                         sys_clk,
   input  wire logic                         nrst,
   input  wire logic                         clkEn,
   input  wire logic                         hostClk,
   input  wire logic                         csN,
   input  wire logic                         serialIn,
   output logic                              serialOut,
   output logic                              serialOeN,
   input  wire logic [dpf_pkg::BYTE_W-1:0]   parallelBusIn,
   output logic [dpf_pkg::BYTE_W-1:0]        parallelBusOut,
   output logic                              parallelBusOeN,
   input  wire logic                         interfaceSelect,
   input  wire logic                         wpN,
   input  wire logic                         resetPinN,
   output logic                              rdyBusyOut,
   output logic                              rdyBusyOeN,
   output logic                              rxValid,
   output logic [dpf_pkg::BYTE_W-1:0]        rxData,
   output logic                              rxFirst,
   input  wire logic                         rxReady,
   output logic                              rxSpace,
   output logic                              rxOverrun,
   output logic                              frameStart,
   output logic                              frameEnd,
   output logic                              clkIdleHigh,
   input  wire logic                         txValid,
   input  wire logic [dpf_pkg::BYTE_W-1:0]   txData,
   output logic                              txReady,
   input  wire logic                         opLaunchReq,
   input  wire logic                         opProgram,
   input  wire logic [dpf_pkg::PAGE_W-1:0]   opPage,
   input  wire logic                         opBuffer,
   input  wire logic                         opDone,
   output logic                              opStart,
   output logic                              opRefused,
   output logic                              busy,
   output logic [1:0]                        bufferBlocked
);
   // ---------------------------------------------------------------
   // Core domain state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic                          csS1;
      logic                          csS2;
      logic                          csS3;
      logic                          sckS1;
      logic                          sckS2;
      logic                          rxTS1;
      logic                          rxTS2;
      logic                          rxTS3;
      logic                          ackS1;
      logic                          ackS2;
      logic                          wpS1;
      logic                          wpS2;
      logic                          rstS1;
      logic                          rstS2;
      logic                          armed;
      logic                          clkIdleHigh;
      logic                          firstPending;
      logic                          rxPush;
      logic                          rxFirst;
      logic [dpf_pkg::BYTE_W-1:0]    rxByte;
      logic                          overrun;
      logic                          frStart;
      logic                          frEnd;
      dpf_pkg::dpf_op_e              opState;
      logic                          busyBuf;
      logic                          opStart;
      logic                          opRefused;
      logic [dpf_pkg::BYTE_W-1:0]    txHold;
      logic                          txReq;
   } dpf_core_s;

   dpf_core_s r;
   dpf_core_s next_r;

   // Link domain signals
   logic [dpf_pkg::BYTE_W-1:0]   rxShift;
   logic [dpf_pkg::BITCNT_W-1:0] rxCnt;
   logic [dpf_pkg::BYTE_W-1:0]   rxHold;
   logic                         rxToggle;
   logic                         rxDone;
   logic [dpf_pkg::BYTE_W-1:0]   rxAssembled;
   logic [dpf_pkg::BYTE_W-1:0]   txShift;
   logic [dpf_pkg::BITCNT_W-1:0] txCnt;
   logic                         txActive;
   logic                         txAck;
   logic                         txReqS1;
   logic                         txReqS2;
   logic                         loadNow;
   logic [dpf_pkg::BYTE_W-1:0]   busOutR;

   // Core helpers
   logic csFall;
   logic csRise;
   logic rxEvt;
   logic devRst;
   logic fifoInReady;
   logic protHit;

   // ---------------------------------------------------------------
   // Link receive side, host clock rising edge
   // ---------------------------------------------------------------
   // Serial bits shift in on the rising edge; select high clears the frame
   always_ff @(posedge hostClk or posedge csN) begin
      if (csN) begin
         rxShift <= dpf_pkg::BYTE_RST;                       // [R5] [R6]
         rxCnt   <= dpf_pkg::FIRST_BIT;
      end else if (interfaceSelect) begin                    // [R16]
         rxShift <= {rxShift[dpf_pkg::BYTE_W-2:0], serialIn}; // [R1] [R4]
         rxCnt   <= rxCnt + 1'b1;
      end
   end

   // Serial byte ends on the eighth bit, parallel every edge
   assign rxDone      = interfaceSelect ? (rxCnt == dpf_pkg::LAST_BIT) : 1'b1; // [R15]
   assign rxAssembled = interfaceSelect ? {rxShift[dpf_pkg::BYTE_W-2:0], serialIn}
                                        : parallelBusIn;    // [R3] [R16]

   // Byte hold and event toggle survive frames, so no select clear here
   always_ff @(posedge hostClk or negedge resetPinN) begin
      if (!resetPinN) begin
         rxHold   <= dpf_pkg::BYTE_RST;
         rxToggle <= 1'b0;
      end else if (!csN && rxDone) begin                     // [R5] [R4]
         rxHold   <= rxAssembled;
         rxToggle <= ~rxToggle;
      end
   end

   // ---------------------------------------------------------------
   // Link transmit side, host clock falling edge
   // ---------------------------------------------------------------
   // Request toggle from the core, two flops before use
   always_ff @(negedge hostClk or negedge resetPinN) begin
      if (!resetPinN) begin
         txReqS1 <= 1'b0;
         txReqS2 <= 1'b0;
      end else begin
         txReqS1 <= r.txReq;
         txReqS2 <= txReqS1;
      end
   end

   // New byte taken only on a byte boundary
   assign loadNow = !csN && (txCnt == dpf_pkg::FIRST_BIT) && (txReqS2 != txAck);

   // Acknowledge toggle, kept across frames to stay paired with the request
   always_ff @(negedge hostClk or negedge resetPinN) begin
      if (!resetPinN) begin
         txAck <= 1'b0;
      end else if (loadNow) begin
         txAck <= ~txAck;
      end
   end

   // Output shifter changes on the falling edge; select high clears it at once
   always_ff @(negedge hostClk or posedge csN) begin
      if (csN) begin
         txShift  <= dpf_pkg::BYTE_RST;
         txCnt    <= dpf_pkg::FIRST_BIT;
         txActive <= 1'b0;
         busOutR  <= dpf_pkg::BYTE_RST;
      end else if (loadNow) begin
         txShift  <= r.txHold;                               // [R2] [R4]
         busOutR  <= r.txHold;                               // [R3] [R4]
         txActive <= 1'b1;
         txCnt    <= interfaceSelect ? 3'h1 : dpf_pkg::FIRST_BIT;
      end else if (txCnt != dpf_pkg::FIRST_BIT) begin
         txShift  <= {txShift[dpf_pkg::BYTE_W-2:0], 1'b0};   // [R2]
         txCnt    <= txCnt + 1'b1;
      end else if (interfaceSelect) begin
         txActive <= 1'b0;   // Serial underrun releases the pin
      end
   end

   // Pad enables: released whenever deselected or on the unused port
   assign serialOut      = txShift[dpf_pkg::BYTE_W-1];
   assign serialOeN      = ~(~csN & interfaceSelect & txActive);    // [R5] [R16]
   assign parallelBusOut = busOutR;
   assign parallelBusOeN = ~(~csN & ~interfaceSelect & txActive);   // [R5] [R16]

   // ---------------------------------------------------------------
   // Core domain
   // ---------------------------------------------------------------
   // Edge detection always on the second and third stages
   assign csFall  = r.csS3 & ~r.csS2;
   assign csRise  = ~r.csS3 & r.csS2;
   assign rxEvt   = r.rxTS3 ^ r.rxTS2;
   assign devRst  = ~r.rstS2;
   assign protHit = opProgram && (opPage < dpf_pkg::PROT_PAGES) && !r.wpS2;

   // Next state of the core
   always_comb begin
      next_r           = r;
      next_r.rxPush    = 1'b0;
      next_r.frStart   = 1'b0;
      next_r.frEnd     = 1'b0;
      next_r.opStart   = 1'b0;
      next_r.opRefused = 1'b0;
      next_r.csS1      = csN;
      next_r.csS2      = r.csS1;
      next_r.csS3      = r.csS2;
      next_r.sckS1     = hostClk;
      next_r.sckS2     = r.sckS1;
      next_r.rxTS1     = rxToggle;
      next_r.rxTS2     = r.rxTS1;
      next_r.rxTS3     = r.rxTS2;
      next_r.ackS1     = txAck;
      next_r.ackS2     = r.ackS1;
      next_r.wpS1      = wpN;
      next_r.wpS2      = r.wpS1;
      next_r.rstS1     = resetPinN;
      next_r.rstS2     = r.rstS1;
      // Holding register refills only when the link has taken the last byte
      if (txValid && txReady) begin
         next_r.txHold = txData;
         next_r.txReq  = ~r.txReq;
      end
      if (devRst) begin
         next_r.armed        = 1'b0;                          // [R8] [R13]
         next_r.clkIdleHigh  = dpf_pkg::IDLE_HI_RST;          // [R12]
         next_r.firstPending = 1'b0;
         next_r.overrun      = 1'b0;
         next_r.opState      = dpf_pkg::OP_IDLE;              // [R8]
         next_r.busyBuf      = 1'b0;
         next_r.txReq        = 1'b0;                          // Pin reset also clears the core request toggle, pairing it with the link acknowledge
      end else begin
         if (csFall) begin
            next_r.armed        = 1'b1;                       // [R13] [R6]
            next_r.clkIdleHigh  = r.sckS2;                    // [R14]
            next_r.firstPending = 1'b1;
            next_r.overrun      = 1'b0;
            next_r.frStart      = 1'b1;
         end
         // Byte event; a lost byte sets the flag after any clear above
         if (rxEvt && r.armed) begin                          // [R13]
            if (fifoInReady) begin
               next_r.rxPush       = 1'b1;
               next_r.rxByte       = rxHold;
               next_r.rxFirst      = r.firstPending;
               next_r.firstPending = 1'b0;
            end else begin
               next_r.overrun = 1'b1;
            end
         end
         if (r.opState == dpf_pkg::OP_BUSY && opDone) begin
            next_r.opState = dpf_pkg::OP_IDLE;                // [R19]
         end
         // Self-timed work launches on the closing select edge
         if (csRise && r.armed) begin
            next_r.frEnd = 1'b1;                              // [R6]
            if (opLaunchReq) begin
               if (r.opState == dpf_pkg::OP_BUSY || protHit) begin
                  next_r.opRefused = 1'b1;                    // [R7] [R18]
               end else begin
                  next_r.opStart = 1'b1;
                  next_r.opState = dpf_pkg::OP_BUSY;          // [R19] [R10]
                  next_r.busyBuf = opBuffer;
               end
            end
         end
      end
   end

   // Core register; nrst is the internal power-on reset
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         r             <= '0;                                 // [R9]
         r.clkIdleHigh <= dpf_pkg::IDLE_HI_RST;               // [R12]
         {r.csS1, r.csS2, r.csS3} <= 3'b111;                  // Select idles high, so no false edge
      end else if (clkEn) begin
         r <= next_r;
      end
   end

   // Receive FIFO, drained by the buffer engine
   dpf_fifo #(
      .W (dpf_pkg::FIFO_W),
      .D (dpf_pkg::FIFO_D)
   ) u_rxFifo (
      .clk      (sys_clk),
      .nrst     (nrst),
      .clkEn    (clkEn),
      .inValid  (r.rxPush),
      .inData   ({r.rxFirst, r.rxByte}),
      .inReady  (fifoInReady),
      .outValid (rxValid),
      .outData  ({rxFirst, rxData}),
      .outReady (rxReady)
   );

   // Core outputs
   assign rxSpace       = fifoInReady;
   assign rxOverrun     = r.overrun;
   assign frameStart    = r.frStart;
   assign frameEnd      = r.frEnd;
   assign clkIdleHigh   = r.clkIdleHigh;
   assign txReady       = (r.txReq == r.ackS2);
   assign opStart       = r.opStart;
   assign opRefused     = r.opRefused;
   assign busy          = (r.opState == dpf_pkg::OP_BUSY);
   assign rdyBusyOut    = 1'b0;                               // Open drain only pulls low
   assign rdyBusyOeN    = ~busy;                              // [R10]
   assign bufferBlocked = busy ? (r.busyBuf ? 2'b10 : 2'b01) : 2'b00; // [R11]

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_launch;
      csRise && r.armed && opLaunchReq && !busy && !protHit && !devRst && clkEn;
   endsequence

   sequence s_protected;
      csRise && r.armed && opLaunchReq && protHit && !devRst && clkEn;
   endsequence

   property p_busyFromLaunch;
      @(posedge sys_clk) disable iff (!nrst)
      s_launch |=> busy && opStart && !rdyBusyOeN;
   endproperty
   a_busyFromLaunch: assert property (p_busyFromLaunch) else $error("busy not raised on launch"); // [R19]

   property p_busyHolds;
      @(posedge sys_clk) disable iff (!nrst)
      busy && !opDone && !devRst |=> busy;
   endproperty
   a_busyHolds: assert property (p_busyHolds) else $error("busy dropped early"); // [R10]

   property p_protRefuse;
      @(posedge sys_clk) disable iff (!nrst)
      s_protected |=> opRefused && !opStart;
   endproperty
   a_protRefuse: assert property (p_protRefuse) else $error("protected page launched"); // [R7]

   property p_resetIdle;
      @(posedge sys_clk) disable iff (!nrst)
      devRst && clkEn |=> !busy && clkIdleHigh && !r.armed;
   endproperty
   a_resetIdle: assert property (p_resetIdle) else $error("reset did not idle"); // [R8]

   property p_modeSample;
      @(posedge sys_clk) disable iff (!nrst)
      csFall && !devRst && clkEn |=> clkIdleHigh == $past(r.sckS2);
   endproperty
   a_modeSample: assert property (p_modeSample) else $error("clock mode not sampled"); // [R14]

   property p_armedPush;
      @(posedge sys_clk) disable iff (!nrst)
      r.rxPush |-> $past(r.armed);
   endproperty
   a_armedPush: assert property (p_armedPush) else $error("byte taken before select fall"); // [R13]

   property p_oneBufBlocked;
      @(posedge sys_clk) disable iff (!nrst)
      s_launch |=> $onehot(bufferBlocked) && (bufferBlocked[1] == $past(opBuffer));
   endproperty
   a_oneBufBlocked: assert property (p_oneBufBlocked) else $error("buffer block wrong"); // [R11]

   property p_deselectRelease;
      @(posedge sys_clk) disable iff (!nrst)
      csN |-> serialOeN && parallelBusOeN;
   endproperty
   a_deselectRelease: assert property (p_deselectRelease) else $error("pin driven while deselected"); // [R5]

   property p_portExclusive;
      @(posedge sys_clk) disable iff (!nrst)
      !serialOeN |-> parallelBusOeN && interfaceSelect;
   endproperty
   a_portExclusive: assert property (p_portExclusive) else $error("both ports driven"); // [R16]
endmodule

`default_nettype wire

// file: rtl/dpf_pkg.sv
// Shared constants and types for the dual-port flash host pin interface
// Rules for this block and its host
// R1 - Serial mode takes every input bit, opcode and address too, on the serial input.
// R2 - Serial mode returns read data bit by bit on the output-only serial pin.
// R3 - Parallel mode moves opcodes, addresses and data over the eight-line two-way bus.
// R4 - Inputs sampled on host clock rising edge; outputs change on falling edge.
// R5 - Chip select high: inputs ignored, serial and parallel outputs stay high impedance.
// R6 - Chip select fall starts an operation, its rise ends it.
// R7 - Write-protect low refuses programming of the lowest 256 pages.
// R8 - Reset pin low aborts work, returns to idle, holds until released.
// R9 - Power-on reset is internal; host need not sequence the reset pin. Link flops rxHold, rxToggle, txAck reset only from that pin, not nrst.
// R10 - Ready/busy open-drain pin pulled low for every self-timed operation.
// R11 - While busy, the array and engaged buffer are blocked; other buffer stays usable.
// R12 - After power-up or reset, default to clock idle high with outputs released.
// R13 - After power-up or reset, instructions accepted only after a chip select fall.
// R14 - Each chip select fall samples idle clock level to pick the clock mode.
// R15 - Serial uses clock, serial input, select; parallel uses clock, bus, select.
// R16 - Interface select high uses serial pins; low uses parallel bus, other ignored.
// R17 - Host keeps chip select high while changing interface select.
// R18 - Host starts no array operation while another one is unfinished.
// R19 - Busy asserts from the launching chip select rise until the operation completes.
package dpf_pkg;

   // ---------------------------------------------------------------
   // Widths and depths
   // ---------------------------------------------------------------
   localparam int BYTE_W   = 8;
   localparam int FIFO_W   = 9;   // Frame-first flag plus one byte
   localparam int FIFO_D   = 16;
   localparam int PAGE_W   = 13;
   localparam int BITCNT_W = 3;

   // ---------------------------------------------------------------
   // Values and counts
   // ---------------------------------------------------------------
   localparam logic [PAGE_W-1:0]   PROT_PAGES   = 13'h0100;  // Pages 0..255 guarded
   localparam logic [BITCNT_W-1:0] LAST_BIT     = 3'h7;
   localparam logic [BITCNT_W-1:0] FIRST_BIT    = 3'h0;
   localparam logic                IDLE_HI_RST  = 1'h1;      // Clock idle high after reset
   localparam logic [BYTE_W-1:0]   BYTE_RST     = 8'h00;

   // ---------------------------------------------------------------
   // Operation state, Gray coded
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_IDLE = 2'b00,
      OP_BUSY = 2'b01
   } dpf_op_e;

endpackage

// file: verification/dpf_host_model.sv
// Host side model that frames bytes onto the flash pins
`timescale 1ns/1ps
`default_nettype none
module dpf_host_model (
   output logic       hostClk,
   output logic       csN,
   output logic       serialIn,
   output logic [7:0] parallelBusIn,
   input  wire logic  interfaceSelect
);
   // ----------------------------------------------------------
   // Pin levels at time zero, clock idle until a frame
   // ----------------------------------------------------------
   initial begin
      hostClk = 1'b1;
      csN = 1'b1;
      serialIn = 1'b0;
      parallelBusIn = 8'h00;
   end

   // Data changes while clock low, device takes it on the rise
   task automatic frame(input logic idle, input logic [7:0] b[$]);
      hostClk = idle;
      #48 csN = 1'b0;
      #40;
      foreach (b[k]) begin
         for (int i = 7; i >= 0; i--) begin
            hostClk = 1'b0;
            serialIn = b[k][i];
            parallelBusIn = b[k];
            #40 hostClk = 1'b1;
            #40;
            if (!interfaceSelect) break;
         end
      end
      hostClk = idle;
      #30 csN = 1'b1;
      // Released lines move, so a stale value cannot pass for data
      serialIn = ~serialIn;
      parallelBusIn = ~parallelBusIn;
   endtask
endmodule
`default_nettype wire

// file: verification/tb.sv
// Self-checking testbench for the flash host pin interface
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        sys_clk, nrst, clkEn, hostClk, csN, serialIn, serialOeN, parallelBusOeN;
   logic        interfaceSelect, wpN, resetPinN, rdyBusyOeN, rxValid, rxFirst, rxReady;
   logic        rxSpace, rxOverrun, clkIdleHigh, txValid, opLaunchReq, opProgram, opBuffer;
   logic        opDone, opStart, opRefused, busy, mBusy, mBuf;
   logic        serialOut, frameStart, frameEnd, txReady;
   logic [7:0]  rdSh;
   int          rdBits = 0;
   int          nFrames = 0;
   int          expFrames = 0;
   logic [7:0]  parallelBusIn, rxData, txData;
   logic [12:0] opPage;
   logic [1:0]  bufferBlocked;
   logic [8:0]  expQ[$];
   int          n_errors = 0;
   int          total_checks = 0;

   dpf_host_model i_dpf_host_model (.hostClk(hostClk), .csN(csN), .serialIn(serialIn),
      .parallelBusIn(parallelBusIn), .interfaceSelect(interfaceSelect));
   dpf_host_if i_dpf_host_if (
      .sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn), .hostClk(hostClk), .csN(csN),
      .serialIn(serialIn), .serialOut(serialOut), .serialOeN(serialOeN), .parallelBusIn(parallelBusIn),
      .parallelBusOut(), .parallelBusOeN(parallelBusOeN), .interfaceSelect(interfaceSelect),
      .wpN(wpN), .resetPinN(resetPinN), .rdyBusyOut(), .rdyBusyOeN(rdyBusyOeN), .rxValid(rxValid),
      .rxData(rxData), .rxFirst(rxFirst), .rxReady(rxReady), .rxSpace(rxSpace), .rxOverrun(rxOverrun),
      .frameStart(frameStart), .frameEnd(frameEnd), .clkIdleHigh(clkIdleHigh), .txValid(txValid),
      .txData(txData), .txReady(txReady), .opLaunchReq(opLaunchReq), .opProgram(opProgram), .opPage(opPage),
      .opBuffer(opBuffer), .opDone(opDone), .opStart(opStart), .opRefused(opRefused), .busy(busy),
      .bufferBlocked(bufferBlocked));

   // ----------------------------------------------------------
   // Clock, checks and verdict
   // ----------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [8:0] seen, input logic [8:0] want);
      total_checks++;
      if (seen !== want) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Every delivered byte must be the next one the model expects
   always @(posedge sys_clk) begin
      if (rxValid === 1'b1 && rxReady === 1'b1)
         chk({rxFirst, rxData}, expQ.size() ? expQ.pop_front() : 9'bx);
      if (frameStart === 1'b1) nFrames++;
   end

   // Host takes read bits on the clock rise while the pin is driven
   always @(posedge hostClk) begin
      if (serialOeN === 1'b0) begin
         rdSh = {rdSh[6:0], serialOut};
         rdBits++;
      end
   end

   // ----------------------------------------------------------
   // Stimulus tasks
   // ----------------------------------------------------------
   task automatic send(input logic idle, input int n, input int keep);
      logic [7:0] b[$];
      for (int i = 0; i < n; i++) begin
         b.push_back(8'($urandom));
         if (i < keep) expQ.push_back({i == 0, b[i]});
      end
      expFrames++;
      i_dpf_host_model.frame(idle, b);
   endtask

   // Bounded wait until the model queue is empty
   task automatic drain;
      int n;
      n = 0;
      do begin @(negedge sys_clk); n++; end while (expQ.size() != 0 && n < 400);
      if (n == 400) begin n_errors++; give_verdict(); end
      repeat (8) @(negedge sys_clk);
   endtask

   // One frame that asks for a self-timed operation at its end
   task automatic launch(input logic prog, input logic [12:0] pg, input logic ok);
      int n;
      opLaunchReq = 1'b1;
      opProgram = prog;
      opPage = pg;
      opBuffer = pg[0];
      send(1'b0, 1, 1);
      n = 0;
      do begin @(negedge sys_clk); n++; end while (!(opStart || opRefused) && n < 80);
      if (n == 80) begin n_errors++; give_verdict(); end
      if (ok) begin mBusy = 1'b1; mBuf = pg[0]; end
      chk({opStart, opRefused, frameEnd, busy, rdyBusyOeN, bufferBlocked},
          {ok, !ok, 1'b1, mBusy, !mBusy, mBusy ? (mBuf ? 2'b10 : 2'b01) : 2'b00});
      opLaunchReq = 1'b0;
      drain();
   endtask

   task automatic done;
      chk(busy, mBusy);
      opDone = 1'b1;
      @(negedge sys_clk) opDone = 1'b0;
      @(negedge sys_clk);
      mBusy = 1'b0;
      chk({busy, rdyBusyOeN, bufferBlocked}, 4'b0100);
   endtask

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      {nrst, resetPinN, opLaunchReq, opProgram, opBuffer, opDone, txValid, mBusy, mBuf} = '0;
      {clkEn, interfaceSelect, wpN, rxReady} = 4'hf;
      opPage = 13'h0000;
      txData = 8'h00;
      void'($urandom(94));
      repeat (20) @(negedge sys_clk);
      nrst = 1'b1;
      resetPinN = 1'b1;
      repeat (6) @(negedge sys_clk);
      chk({busy, rdyBusyOeN, clkIdleHigh, serialOeN, parallelBusOeN}, 5'b01111);
      send(1'b1, 3, 3);
      drain();
      chk(clkIdleHigh, 1'b1);
      // Readout in mode 3: one byte handed over, shifted out MSB first
      txData = 8'($urandom);
      txValid = 1'b1;
      @(negedge sys_clk) txValid = 1'b0;
      chk(txReady, 1'b0);
      send(1'b1, 2, 2);
      drain();
      chk(rdBits, 8);
      chk(rdSh, txData);
      chk(txReady, 1'b1);
      send(1'b0, 2, 2);
      drain();
      chk(clkIdleHigh, 1'b0);
      interfaceSelect = 1'b0;
      send(1'b1, 4, 4);
      drain();
      // Fill with the consumer stalled: the seventeenth byte is lost
      rxReady = 1'b0;
      send(1'b0, 17, 16);
      repeat (8) @(negedge sys_clk);
      chk({rxSpace, rxOverrun}, 2'b01);
      rxReady = 1'b1;
      drain();
      chk({rxSpace, serialOeN, parallelBusOeN}, 3'b111);
      interfaceSelect = 1'b1;
      wpN = 1'b0;
      repeat (4) @(negedge sys_clk);
      launch(1'b1, 13'h00ff, 1'b0);
      launch(1'b1, 13'h0100, 1'b1);
      launch(1'b0, 13'h0003, 1'b0);
      done();
      launch(1'b0, 13'h0000, 1'b1);
      resetPinN = 1'b0;
      repeat (4) @(negedge sys_clk);
      mBusy = 1'b0;
      chk({busy, rdyBusyOeN, clkIdleHigh}, 3'b011);
      resetPinN = 1'b1;
      repeat (6) @(negedge sys_clk);
      wpN = 1'b1;
      launch(1'b1, 13'h0000, 1'b1);
      done();
      chk(nFrames, expFrames);
      give_verdict();
   end

   initial begin
      #300000;
      n_errors++;
      give_verdict();
   end
endmodule
`default_nettype wire
